//--- rtl/fbs_pkg.sv
// Package for the fieldbus slave host signal block
package fbs_pkg;
    localparam int unsigned IO_COUNT = 32;
    // Status input positions, counted from zero
    localparam int unsigned X_COMM_VALID = 1;
    localparam int unsigned X_TROUBLE_DONE = 2;
    localparam int unsigned X_FAULT = 3;
    localparam int unsigned X_SYNC_MODE = 5;
    localparam int unsigned X_SYNC_RECV = 6;
    // Request output positions
    localparam int unsigned Y_INPUT_REFRESH = 0;
    localparam int unsigned Y_TROUBLE_REQ = 2;
    localparam int unsigned Y_FAULT_CLEAR = 3;
    // Buffer memory word addresses
    localparam logic [11:0] ERROR_CODE_WORD_OFS = 12'h07f8;
    localparam logic [11:0] CURRENT_WATCHDOG_VALUE_OFS = 12'h08d1;
    localparam logic [15:0] ERROR_CODE_RST = 16'h0000;
    localparam logic [15:0] WATCHDOG_RST = 16'h0000;
    localparam logic [15:0] WATCHDOG_MAX = 16'hfde8;
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;

    // Events reported by the network side
    typedef struct packed {
        logic link_ok;
        logic timeout;
        logic sync_cmd;
        logic unsync_cmd;
        logic trouble_sent;
        logic err_event;
        logic [15:0] err_code;
        logic wdt_load;
        logic [15:0] wdt_value;
    } fbs_net_t;

    typedef enum logic [1:0] {TN_IDLE, TN_BUSY, TN_DONE} fbs_tn_state_t;
endpackage

//--- rtl/fbs_host_signals.sv
// Host facing status and request bits of the fieldbus slave
// Behaviour
// - 32 status inputs, 32 request outputs, zero-based
// - Comm-valid rises once master exchange works
// - Output receive area updates while comm-valid
// - Comm-valid drops on communication time-out
// - Watchdog zero: no time-out, data held
// - Watchdog 1..65000 enables time-out detection
// - Current watchdog value readable in memory
// - Trouble-notify-done rises when notification finishes
// - Trouble request ignored while comm-valid low
// - Request release then done falls
// - Error sets fault flag and code
// - Fault cleared by clear request or reset
// - SYNC command sets sync-mode flag
// - UNSYNC, comm loss, reset clear sync-mode
// - SYNC lamp follows sync-mode flag
// - SYNC command sets sync-received flag
// - Further SYNC toggles sync-received, mode stays
// - Sync-received cleared when SYNC mode ends
// - Error reset zeroes the error code
// - Refresh low sends zero input data
`timescale 1ns/1ps
module fbs_host_signals
    import fbs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [IO_COUNT-1:0] host_req,
    output logic [IO_COUNT-1:0] host_status,
    input wire fbs_net_t net_ev,
    output logic trouble_start,
    input wire logic [15:0] master_out_data,
    output logic [15:0] out_recv_data,
    input wire logic [15:0] in_send_data,
    output logic [15:0] master_in_data,
    output logic sync_lamp,
    input wire logic [11:0] bm_addr,
    output logic [15:0] bm_rdata
);
    // Host requests come from a foreign clock: three stages, act on agreement
    logic [2:0] s1_q, s2_q, s3_q, req_q;
    logic [2:0] s1_d, s2_d, s3_d, req_d;
    logic [2:0] raw;
    assign raw = {host_req[Y_FAULT_CLEAR], host_req[Y_TROUBLE_REQ], host_req[Y_INPUT_REFRESH]};
    always_comb begin
        s1_d = raw;
        s2_d = s1_q;
        s3_d = s2_q;
        req_d = req_q;
        for (int i = 0; i < 3; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                req_d[i] = s3_q[i];
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
            req_q <= 3'h0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            req_q <= req_d;
        end
    end
    logic refresh_req, trouble_req, clear_req;
    assign refresh_req = req_q[0];
    assign trouble_req = req_q[1];
    assign clear_req = req_q[2];

    // Link and data state
    logic comm_q, comm_d;
    logic [15:0] wdt_q, wdt_d, recv_q, recv_d, send_q, send_d;
    logic fault_q, fault_d, smode_q, smode_d, srecv_q, srecv_d;
    logic [15:0] ecode_q, ecode_d;
    logic wdt_on;
    assign wdt_on = (wdt_q != 16'h0000) && (wdt_q <= WATCHDOG_MAX);

    always_comb begin
        comm_d = comm_q;
        wdt_d = wdt_q;
        recv_d = recv_q;
        send_d = 16'h0000;
        fault_d = fault_q;
        ecode_d = ecode_q;
        smode_d = smode_q;
        srecv_d = srecv_q;
        if (net_ev.wdt_load) begin
            wdt_d = net_ev.wdt_value;
        end
        if (net_ev.link_ok) begin
            comm_d = 1'b1;
        end
        // Time-out only counts when the watchdog is enabled
        if (net_ev.timeout && wdt_on) begin
            comm_d = 1'b0;
        end
        // Receive area tracks master only while valid, else held
        if (comm_q) begin
            recv_d = master_out_data;
        end
        // Zeros go out unless refresh is on and comm is valid
        if (comm_q && refresh_req) begin
            send_d = in_send_data;
        end
        // Clear first so a same-cycle error wins
        if (clear_req) begin
            fault_d = 1'b0;
            ecode_d = ERROR_CODE_RST;
        end
        if (net_ev.err_event) begin
            fault_d = 1'b1;
            ecode_d = net_ev.err_code;
        end
        // SYNC enters mode or toggles receive flag
        if (net_ev.sync_cmd) begin
            smode_d = 1'b1;
            srecv_d = smode_q ? ~srecv_q : 1'b1;
        end
        if (net_ev.unsync_cmd || !comm_d) begin
            smode_d = 1'b0;
            srecv_d = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            comm_q <= 1'b0;
            wdt_q <= WATCHDOG_RST;
            recv_q <= 16'h0000;
            send_q <= 16'h0000;
            fault_q <= 1'b0;
            ecode_q <= ERROR_CODE_RST;
            smode_q <= 1'b0;
            srecv_q <= 1'b0;
        end else begin
            comm_q <= comm_d;
            wdt_q <= wdt_d;
            recv_q <= recv_d;
            send_q <= send_d;
            fault_q <= fault_d;
            ecode_q <= ecode_d;
            smode_q <= smode_d;
            srecv_q <= srecv_d;
        end
    end

    // Trouble notification four-phase handshake
    fbs_tn_state_t tn_q, tn_d;
    always_comb begin
        tn_d = tn_q;
        unique case (tn_q)
            TN_IDLE: begin
                // Request ignored without a valid link
                if (trouble_req && comm_q) begin
                    tn_d = TN_BUSY;
                end
            end
            TN_BUSY: begin
                // Done once the network reports it sent
                if (net_ev.trouble_sent) begin
                    tn_d = TN_DONE;
                end
            end
            TN_DONE: begin
                // Done holds until the host releases
                if (!trouble_req) begin
                    tn_d = TN_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tn_q <= TN_IDLE;
        end else begin
            tn_q <= tn_d;
        end
    end
    assign trouble_start = (tn_q == TN_IDLE) && trouble_req && comm_q;

    // Status word, unused positions forced low
    logic [IO_COUNT-1:0] status_q, status_d;
    always_comb begin
        status_d = STATUS_RST;
        status_d[X_COMM_VALID] = comm_q;
        status_d[X_TROUBLE_DONE] = (tn_q == TN_DONE);
        status_d[X_FAULT] = fault_q;
        status_d[X_SYNC_MODE] = smode_q;
        status_d[X_SYNC_RECV] = srecv_q;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end
    assign host_status = status_q;
    // Lamp mirrors the same register as the flag
    assign sync_lamp = status_q[X_SYNC_MODE];
    assign out_recv_data = recv_q;
    assign master_in_data = send_q;

    // Buffer memory read port, other addresses read zero
    always_comb begin
        bm_rdata = 16'h0000;
        if (bm_addr == ERROR_CODE_WORD_OFS) begin
            bm_rdata = ecode_q;
        end else if (bm_addr == CURRENT_WATCHDOG_VALUE_OFS) begin
            bm_rdata = wdt_q;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_tn_req;
        tn_q == TN_IDLE && trouble_req && comm_q;
    endsequence
    sequence s_tn_sent;
        tn_q == TN_BUSY && net_ev.trouble_sent;
    endsequence

    chk_tn_done_rise: assert property (s_tn_sent |=> ##1 host_status[X_TROUBLE_DONE])
        else $error("Done not raised after notification");
    chk_tn_ignore: assert property (!comm_q && tn_q == TN_IDLE |=> tn_q == TN_IDLE)
        else $error("Trouble request taken without link");
    chk_tn_release: assert property (tn_q == TN_DONE && !trouble_req |=> ##1
        !host_status[X_TROUBLE_DONE])
        else $error("Done not dropped after release");
    chk_tn_start: assert property (s_tn_req |=> tn_q == TN_BUSY)
        else $error("Request did not start notification");
    chk_timeout_drop: assert property (net_ev.timeout && wdt_on |=> ##1
        !host_status[X_COMM_VALID])
        else $error("Comm-valid kept after time-out");
    chk_wdt_zero: assert property (comm_q && wdt_q == 16'h0000 && !net_ev.wdt_load |=> comm_q)
        else $error("Comm-valid lost with watchdog off");
    chk_fault_set: assert property (net_ev.err_event |=> fault_q && ecode_q ==
        $past(net_ev.err_code))
        else $error("Error not captured");
    chk_fault_clear: assert property (clear_req && !net_ev.err_event |=>
        !fault_q && ecode_q == 16'h0000)
        else $error("Fault not cleared");
    chk_sync_toggle: assert property (net_ev.sync_cmd && smode_q && comm_d &&
        !net_ev.unsync_cmd |=> smode_q && srecv_q != $past(srecv_q))
        else $error("Sync receive did not toggle");
    chk_sync_end: assert property (net_ev.unsync_cmd |=> !smode_q && !srecv_q)
        else $error("Sync mode not ended");
    chk_lamp: assert property (sync_lamp == host_status[X_SYNC_MODE])
        else $error("Lamp differs from flag");
    chk_unused_low: assert property ((host_status & 32'hffff_ff91) == 32'h0000_0000)
        else $error("Unused status bit high");
    chk_zero_send: assert property (!refresh_req |=> master_in_data == 16'h0000)
        else $error("Data sent while refresh off");

    // Link, data and watchdog paths
    chk_link_up: assert property (net_ev.link_ok && !net_ev.timeout |=>
        comm_q)
        else $error("Comm-valid not raised on link");
    chk_recv_track: assert property (comm_q |=>
        out_recv_data == $past(master_out_data))
        else $error("Receive area not updated");
    chk_recv_hold: assert property (!comm_q |=>
        $stable(out_recv_data))
        else $error("Receive area changed without link");
    chk_wdt_load: assert property (net_ev.wdt_load |=>
        wdt_q == $past(net_ev.wdt_value))
        else $error("Watchdog value not applied");
    chk_send_pass: assert property (comm_q && refresh_req |=>
        master_in_data == $past(in_send_data))
        else $error("Input data not forwarded");

    // Sync, request and flag timing
    chk_sync_enter: assert property (net_ev.sync_cmd && !smode_q && comm_d &&
        !net_ev.unsync_cmd |=> smode_q && srecv_q)
        else $error("Sync mode not entered");
    chk_sync_loss: assert property (comm_q && !comm_d |=>
        !smode_q && !srecv_q)
        else $error("Sync flags kept after link loss");
    chk_sync_lamp_state: assert property (1'b1 |=>
        sync_lamp == $past(smode_q))
        else $error("Lamp lags sync state");
    chk_req_agree: assert property (s2_q[1] == s3_q[1] |=>
        trouble_req == $past(s3_q[1]))
        else $error("Request not taken on agreement");
    chk_tn_hold: assert property (tn_q == TN_DONE && trouble_req |=>
        tn_q == TN_DONE)
        else $error("Done dropped while request held");
    chk_fault_flag: assert property (1'b1 |=>
        host_status[X_FAULT] == $past(fault_q))
        else $error("Fault flag lags its state");
endmodule

//--- test/fbs_cpu_model.sv
// Host CPU model that owns the request outputs
`timescale 1ns/1ps
module fbs_cpu_model
    import fbs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [IO_COUNT-1:0] host_status,
    output logic [IO_COUNT-1:0] host_req
);
    initial host_req = '0;
    task automatic drive(input int unsigned b, input logic v);
        @(negedge sys_clk);
        if (b == Y_INPUT_REFRESH || b == Y_TROUBLE_REQ || b == Y_FAULT_CLEAR) begin
            host_req[b] = v;
        end
    endtask
    // receive area trusted only while comm valid
    function automatic logic recv_ok();
        return host_status[X_COMM_VALID];
    endfunction
endmodule

//--- test/testbench.sv
// Self-checking bench for the fieldbus slave host signals
`timescale 1ns/1ps
module testbench
    import fbs_pkg::*;
;
    localparam logic [6:0] LINK = 7'h40, TMO = 7'h20, SYN = 7'h10, UNS = 7'h08;
    localparam logic [6:0] SENT = 7'h04, ERR = 7'h02, WDT = 7'h01;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [IO_COUNT-1:0] host_req;
    logic [IO_COUNT-1:0] host_status;
    fbs_net_t net_ev = '0;
    logic trouble_start;
    logic sync_lamp;
    logic [15:0] master_out_data = 16'h0000;
    logic [15:0] out_recv_data;
    logic [15:0] in_send_data = 16'h0000;
    logic [15:0] master_in_data;
    logic [11:0] bm_addr = 12'h000;
    logic [15:0] bm_rdata;
    int num_errors = 0;
    int checked = 0;
    int starts = 0;

    fbs_host_signals fbs_host_signals_i (.sys_clk(sys_clk), .rstn(rstn), .host_req(host_req),
        .host_status(host_status), .net_ev(net_ev), .trouble_start(trouble_start),
        .master_out_data(master_out_data), .out_recv_data(out_recv_data),
        .in_send_data(in_send_data), .master_in_data(master_in_data),
        .sync_lamp(sync_lamp), .bm_addr(bm_addr), .bm_rdata(bm_rdata));
    fbs_cpu_model cpu_i (.sys_clk(sys_clk), .host_status(host_status), .host_req(host_req));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (trouble_start === 1'b1) starts <= starts + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Event fields sit in struct order; code and watchdog share v
    task automatic ev(input logic [6:0] f, input logic [15:0] v);
        @(negedge sys_clk);
        net_ev = fbs_net_t'({f[6:1], v, f[0], v});
        @(negedge sys_clk);
        net_ev = '0;
    endtask
    task automatic wt(input int unsigned b, input logic v);
        for (int i = 0; i < 12 && host_status[b] !== v; i++) @(negedge sys_clk);
        chk(host_status[b], v);
        chk(host_status & ~32'h0000_006e, 32'h0000_0000);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(negedge sys_clk);
        bm_addr = a;
        #1;
        chk(bm_rdata, e);
    endtask
    task automatic final_report();
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole sequence needs well under 2000 cycles
    initial begin
        #200us;
        num_errors++;
        final_report();
    end

    initial begin
        repeat (20) @(negedge sys_clk);
        rstn = 1'b1;
        chk(host_status, STATUS_RST);
        rd(ERROR_CODE_WORD_OFS, ERROR_CODE_RST);
        rd(12'h0100, 16'h0000);
        cpu_i.drive(Y_TROUBLE_REQ, 1'b1);
        repeat (10) @(negedge sys_clk);
        chk(starts, 0);
        chk(host_status[X_TROUBLE_DONE], 1'b0);
        cpu_i.drive(Y_TROUBLE_REQ, 1'b0);
        repeat (6) @(negedge sys_clk);
        ev(LINK, 16'h0000);
        wt(X_COMM_VALID, 1'b1);
        master_out_data = 16'h5a5a;
        in_send_data = 16'hc3a5;
        repeat (3) @(negedge sys_clk);
        if (cpu_i.recv_ok() === 1'b1) chk(out_recv_data, 16'h5a5a);
        chk(master_in_data, 16'h0000);
        cpu_i.drive(Y_INPUT_REFRESH, 1'b1);
        repeat (8) @(negedge sys_clk);
        chk(master_in_data, 16'hc3a5);
        cpu_i.drive(Y_TROUBLE_REQ, 1'b1);
        for (int i = 0; i < 12 && starts == 0; i++) @(negedge sys_clk);
        chk(starts, 1);
        ev(SENT, 16'h0000);
        wt(X_TROUBLE_DONE, 1'b1);
        cpu_i.drive(Y_TROUBLE_REQ, 1'b0);
        wt(X_TROUBLE_DONE, 1'b0);
        ev(ERR, 16'h1234);
        wt(X_FAULT, 1'b1);
        rd(ERROR_CODE_WORD_OFS, 16'h1234);
        cpu_i.drive(Y_FAULT_CLEAR, 1'b1);
        wt(X_FAULT, 1'b0);
        cpu_i.drive(Y_FAULT_CLEAR, 1'b0);
        rd(ERROR_CODE_WORD_OFS, 16'h0000);
        ev(SYN, 16'h0000);
        wt(X_SYNC_MODE, 1'b1);
        chk(host_status[X_SYNC_RECV], 1'b1);
        @(negedge sys_clk);
        chk(sync_lamp, 1'b1);
        ev(SYN, 16'h0000);
        wt(X_SYNC_RECV, 1'b0);
        chk(host_status[X_SYNC_MODE], 1'b1);
        ev(UNS, 16'h0000);
        wt(X_SYNC_MODE, 1'b0);
        chk(host_status[X_SYNC_RECV], 1'b0);
        @(negedge sys_clk);
        chk(sync_lamp, 1'b0);
        // Pass 0 disables the time-out, pass 1 uses the top valid value
        for (int k = 0; k < 2; k++) begin
            ev(WDT, k ? WATCHDOG_MAX : 16'h0000);
            rd(CURRENT_WATCHDOG_VALUE_OFS, k ? WATCHDOG_MAX : 16'h0000);
            ev(SYN, 16'h0000);
            ev(TMO, 16'h0000);
            repeat (4) @(negedge sys_clk);
            chk(host_status[X_COMM_VALID], k ? 1'b0 : 1'b1);
            chk(host_status[X_SYNC_MODE], k ? 1'b0 : 1'b1);
            chk(host_status[X_SYNC_RECV], k ? 1'b0 : 1'b1);
        end
        master_out_data = 16'h0f0f;
        repeat (4) @(negedge sys_clk);
        chk(out_recv_data, 16'h5a5a);
        chk(master_in_data, 16'h0000);
        ev(LINK, 16'h0000);
        ev(ERR, 16'h00aa);
        ev(SYN, 16'h0000);
        wt(X_SYNC_MODE, 1'b1);
        rd(ERROR_CODE_WORD_OFS, 16'h00aa);
        ev(WDT, 16'hfde9);
        ev(TMO, 16'h0000);
        repeat (4) @(negedge sys_clk);
        chk(host_status[X_COMM_VALID], 1'b1);
        rstn = 1'b0;
        @(negedge sys_clk);
        chk(host_status, STATUS_RST);
        chk(sync_lamp, 1'b0);
        rstn = 1'b1;
        rd(ERROR_CODE_WORD_OFS, ERROR_CODE_RST);
        final_report();
    end
endmodule
